/* File: common/obcl_cfg_if.sv */
// Carries the latched configuration fields from the loader to the top.
// Assumes both ends sit on the same system clock.
`timescale 1ns/1ps
interface obcl_cfg_if;
    logic                  valid;
    logic [7:0]            raw;
    logic                  pullup_sel;
    logic                  mode_sel;
    obcl_pkg::obcl_clksrc_t src;
    logic                  osc_lock;

    modport loader (output valid, raw, pullup_sel, mode_sel, src, osc_lock);
    modport user   (input  valid, raw, pullup_sel, mode_sel, src, osc_lock);
endinterface : obcl_cfg_if

/* File: common/obcl_pkg.sv */
// Constants, types and decode helpers for the boot configuration loader.
// Assumes one system clock domain and an active-low asynchronous reset.
package obcl_pkg;

    // ==========================================================
    // Configuration byte
    // ==========================================================
    localparam logic [11:0] OB_FLASH_ADDR  = 12'h080;
    localparam int          OB_PULLUP_BIT  = 4;
    localparam int          OB_MODE_BIT    = 3;
    localparam int          OB_SRC_HI_BIT  = 2;
    localparam int          OB_SRC_LO_BIT  = 1;
    localparam int          OB_LOCK_BIT    = 0;
    localparam logic [7:0]  OB_FIXED_MASK  = 8'he0;

    // ==========================================================
    // Register map, byte addresses
    // ==========================================================
    localparam logic [7:0]  REG_CTRL       = 8'h00;
    localparam logic [7:0]  REG_PU3        = 8'h04;
    localparam logic [7:0]  REG_PROT       = 8'h08;
    localparam logic [7:0]  REG_SEC        = 8'h0c;
    localparam logic [7:0]  REG_STAT       = 8'h10;
    localparam logic [7:0]  REG_OPTB       = 8'h80;

    localparam int          CTRL_STOP_BIT  = 0;
    localparam int          CTRL_WDTLS_BIT = 1;
    localparam logic [1:0]  CTRL_RESET     = 2'h2;
    localparam int          PU3_RESET_PORT_PULLUP_BIT_BIT   = 4;
    localparam logic [7:0]  PU3_RESET      = 8'h00;
    localparam int          SEC_NO_BLKERS  = 0;
    localparam int          SEC_NO_CHIPERS = 1;
    localparam int          SEC_NO_WRITE   = 2;
    localparam logic [2:0]  SEC_RESET      = 3'h0;
    localparam logic [15:0] PROT_RESET     = 16'h0000;

    // ==========================================================
    // Flash organisation
    // ==========================================================
    localparam int          ERASE_BLOCK_BYTES = 256;
    localparam int          BLOCKS_PER_KB     = 4;
    localparam int          BLOCK_W           = 4;
    localparam int          PROT_W            = 16;

    typedef enum logic [1:0] {
        OBCL_SRC_BAD,
        OBCL_SRC_EXT,
        OBCL_SRC_HSI
    } obcl_clksrc_t;

    typedef enum logic [1:0] {
        OBCL_OP_BLK_ERASE,
        OBCL_OP_WRITE,
        OBCL_OP_CHIP_ERASE,
        OBCL_OP_NONE
    } obcl_op_t;

    function automatic obcl_clksrc_t obcl_decode_src(input logic [1:0] sel);
        if (sel[1]) begin
            return OBCL_SRC_HSI;
        end else if (sel[0]) begin
            return OBCL_SRC_EXT;
        end
        return OBCL_SRC_BAD;
    endfunction : obcl_decode_src

endpackage : obcl_pkg

/* File: design/obcl_loader.sv */
// Fetches the configuration byte from flash after reset and latches it.
// Assumes the flash answers a held request with a one-cycle acknowledge.
`timescale 1ns/1ps
module obcl_loader (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        reset_pin_in,
    output logic             flash_rd_req,
    output logic [11:0]      flash_rd_addr,
    input  wire logic        flash_rd_ack,
    input  wire logic [7:0]  flash_rd_data,
    obcl_cfg_if.loader       cfg
);
    typedef enum logic [1:0] {OBCL_LD_IDLE, OBCL_LD_REQ, OBCL_LD_DONE} obcl_ld_t;

    obcl_ld_t   state_q;
    logic [7:0] raw_q;
    logic       valid_q;

    // ==========================================================
    // Fetch sequence
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= OBCL_LD_IDLE;
            valid_q <= 1'b0;
            raw_q   <= 8'h00;
        end else begin
            case (state_q)
                OBCL_LD_IDLE: begin
                    valid_q <= 1'b0;
                    if (reset_pin_in) begin
                        state_q <= OBCL_LD_REQ;
                    end
                end
                OBCL_LD_REQ: begin
                    if (!reset_pin_in) begin
                        state_q <= OBCL_LD_IDLE;
                    end else if (flash_rd_ack) begin
                        raw_q   <= flash_rd_data;
                        valid_q <= 1'b1;
                        state_q <= OBCL_LD_DONE;
                    end
                end
                OBCL_LD_DONE: begin
                    // A reset through the pin starts a fresh fetch when the mode bit selects the reset pin
                    if (raw_q[obcl_pkg::OB_MODE_BIT] && !reset_pin_in) begin
                        valid_q <= 1'b0;
                        state_q <= OBCL_LD_IDLE;
                    end
                end
                default: begin
                    state_q <= OBCL_LD_IDLE;
                    valid_q <= 1'b0;
                end
            endcase
        end
    end

    assign flash_rd_req   = (state_q == OBCL_LD_REQ);
    assign flash_rd_addr  = obcl_pkg::OB_FLASH_ADDR;
    assign cfg.valid      = valid_q;
    assign cfg.raw        = raw_q;
    assign cfg.pullup_sel = raw_q[obcl_pkg::OB_PULLUP_BIT];
    assign cfg.mode_sel   = raw_q[obcl_pkg::OB_MODE_BIT];
    assign cfg.src        = obcl_pkg::obcl_decode_src(raw_q[obcl_pkg::OB_SRC_HI_BIT:obcl_pkg::OB_SRC_LO_BIT]);
    assign cfg.osc_lock   = raw_q[obcl_pkg::OB_LOCK_BIT];

    // ==========================================================
    // Checks
    // ==========================================================
    sequence s_fetch_done;
        flash_rd_req && flash_rd_ack && reset_pin_in;
    endsequence

    property p_latch_one_step;
        @(posedge pclk) disable iff (!presetn)
        s_fetch_done |=> valid_q && (raw_q == $past(flash_rd_data));
    endproperty
    a_latch_one_step: assert property (p_latch_one_step) else $error("config byte not latched");

    property p_pin_holds_reset;
        @(posedge pclk) disable iff (!presetn)
        (!valid_q && !reset_pin_in) |=> !valid_q;
    endproperty
    a_pin_holds_reset: assert property (p_pin_holds_reset) else $error("released while pin low");
endmodule : obcl_loader

/* File: design/obcl_top.sv */
// Boot configuration loader: applies the flash option byte to pins and clocks, and checks
// flash rewrite permissions, with an APB register slave.
// Assumes the flash, oscillators and ports are outside and act on its outputs.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
module obcl_top #(
    parameter int FLASH_KB = 4
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic [7:0]  paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             flash_rd_req,
    output logic [11:0]      flash_rd_addr,
    input  wire logic        flash_rd_ack,
    input  wire logic [7:0]  flash_rd_data,
    input  wire logic        reset_pin_in,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        op_valid,
    input  wire logic [1:0]  op_cmd,
    input  wire logic        op_from_programmer,
    input  wire logic [3:0]  op_block,
    output logic             core_reset_n,
    output logic             reset_pin_pullup_en,
    output logic             reset_shared_input_port,
    output logic             ext_clock_sel,
    output logic             clock_shared_io_en,
    output logic             lowspeed_osc_run,
    output logic             wdt_clk_en,
    output logic             wdt_clk_forced_ls,
    output logic             timer_clk_en,
    output logic             op_grant,
    output logic             op_deny,
    output logic             op_erase_all,
    output logic             op_write_block
);
    localparam int NUM_BLOCKS = FLASH_KB * obcl_pkg::BLOCKS_PER_KB;

    obcl_cfg_if cfg ();

    logic              ld_req;
    logic [11:0]       ld_addr;
    logic [1:0]        ctrl_q;
    logic [7:0]        pu3_q;
    logic [15:0]       prot_q;
    logic [2:0]        sec_q;
    logic              pready_q;
    logic              pslverr_q;
    logic [31:0]       prdata_q;
    logic              core_reset_n_q;
    logic              pullup_q;
    logic              port_q;
    logic              ext_clk_q;
    logic              io_en_q;
    logic              osc_run_q;
    logic              wdt_en_q;
    logic              wdt_ls_q;
    logic              timer_q;
    logic              grant_q;
    logic              deny_q;
    logic              erase_all_q;
    logic              write_block_q;
    logic              apb_done;
    logic              mapped;
    logic [31:0]       rd_mux;
    logic              osc_run_d;
    logic              op_ok;

    obcl_loader u_loader (
        .pclk          (pclk),
        .presetn       (presetn),
        .reset_pin_in  (reset_pin_in),
        .flash_rd_req  (ld_req),
        .flash_rd_addr (ld_addr),
        .flash_rd_ack  (flash_rd_ack),
        .flash_rd_data (flash_rd_data),
        .cfg           (cfg)
    );

    // Flash request is held until acknowledged or the pin drops, so it is passed on as is
    assign flash_rd_req  = ld_req;
    assign flash_rd_addr = ld_addr;

    // ==========================================================
    // APB slave
    // ==========================================================
    // One wait state keeps prdata and pready straight from flops
    assign apb_done = psel && penable && pready_q;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            obcl_pkg::REG_CTRL: rd_mux = {30'h0, ctrl_q};
            obcl_pkg::REG_PU3:  rd_mux = {24'h0, pu3_q};
            obcl_pkg::REG_PROT: rd_mux = {16'h0, prot_q};
            obcl_pkg::REG_SEC:  rd_mux = {29'h0, sec_q};
            obcl_pkg::REG_STAT: rd_mux = {16'h0, 8'(NUM_BLOCKS), 3'h0,
                                          ((cfg.raw & obcl_pkg::OB_FIXED_MASK) != obcl_pkg::OB_FIXED_MASK),
                                          (cfg.src == obcl_pkg::OBCL_SRC_BAD), osc_run_q,
                                          reset_pin_in, cfg.valid};
            obcl_pkg::REG_OPTB: rd_mux = {24'h0, cfg.raw};
            default:            mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0000_0000;
        end else begin
            pready_q  <= psel && penable && !pready_q;
            pslverr_q <= psel && penable && !pready_q && !mapped;
            prdata_q  <= (psel && penable && !pready_q && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= obcl_pkg::CTRL_RESET;
            pu3_q  <= obcl_pkg::PU3_RESET;
            prot_q <= obcl_pkg::PROT_RESET;
            sec_q  <= obcl_pkg::SEC_RESET;
        end else if (apb_done && pwrite) begin
            case (paddr)
                obcl_pkg::REG_CTRL: ctrl_q <= pwdata[1:0];
                obcl_pkg::REG_PU3:  pu3_q  <= pwdata[7:0];
                obcl_pkg::REG_PROT: prot_q <= pwdata[15:0];
                obcl_pkg::REG_SEC:  sec_q  <= pwdata[2:0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Reset pin, clock pin and core reset
    // ==========================================================
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            core_reset_n_q <= 1'b0;
            pullup_q       <= 1'b0;
            port_q         <= 1'b0;
            ext_clk_q      <= 1'b0;
            io_en_q        <= 1'b0;
        end else begin
            core_reset_n_q <= cfg.valid;
            if (cfg.mode_sel) begin
                pullup_q <= cfg.pullup_sel;
            end else begin
                pullup_q <= pu3_q[obcl_pkg::PU3_RESET_PORT_PULLUP_BIT_BIT];
            end
            // Port read stays zero while the pin is a reset input
            port_q    <= cfg.valid && !cfg.mode_sel && reset_pin_in;
            // A prohibited select falls back to the internal oscillator
            ext_clk_q <= cfg.valid && (cfg.src == obcl_pkg::OBCL_SRC_EXT);
            io_en_q   <= cfg.valid && (cfg.src != obcl_pkg::OBCL_SRC_EXT);
        end
    end

    // ==========================================================
    // Low-speed oscillator, watchdog and interval timer clocks
    // ==========================================================
    assign osc_run_d = cfg.osc_lock || !ctrl_q[obcl_pkg::CTRL_STOP_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_run_q <= 1'b1;
            wdt_en_q  <= 1'b0;
            wdt_ls_q  <= 1'b0;
            timer_q   <= 1'b0;
        end else begin
            osc_run_q <= osc_run_d;
            wdt_ls_q  <= cfg.osc_lock;
            if (cfg.osc_lock) begin
                wdt_en_q <= 1'b1;
            end else begin
                wdt_en_q <= ctrl_q[obcl_pkg::CTRL_WDTLS_BIT] && !halt_mode && !stop_mode
                            && osc_run_d;
            end
            // STOP mode does not gate the interval timer
            timer_q <= osc_run_d;
        end
    end

    // ==========================================================
    // Flash rewrite permission
    // ==========================================================
    always_comb begin
        op_ok = 1'b0;
        case (obcl_pkg::obcl_op_t'(op_cmd))
            obcl_pkg::OBCL_OP_BLK_ERASE: begin
                // Smallest erase is one whole block
                op_ok = (int'(op_block) < NUM_BLOCKS) && (op_from_programmer ? !sec_q[obcl_pkg::SEC_NO_BLKERS]
                        : !prot_q[op_block]);
            end
            obcl_pkg::OBCL_OP_WRITE: begin
                op_ok = (int'(op_block) < NUM_BLOCKS) && (op_from_programmer ? !sec_q[obcl_pkg::SEC_NO_WRITE]
                        : !prot_q[op_block]);
            end
            obcl_pkg::OBCL_OP_CHIP_ERASE: begin
                op_ok = op_from_programmer && !sec_q[obcl_pkg::SEC_NO_CHIPERS];
            end
            default: op_ok = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            grant_q       <= 1'b0;
            deny_q        <= 1'b0;
            erase_all_q   <= 1'b0;
            write_block_q <= 1'b0;
        end else begin
            grant_q     <= op_valid && core_reset_n_q && op_ok;
            deny_q      <= op_valid && !(core_reset_n_q && op_ok);
            erase_all_q <= op_valid && core_reset_n_q && op_ok && (op_cmd == 2'(obcl_pkg::OBCL_OP_CHIP_ERASE));
            if (op_valid) begin
                write_block_q <= op_from_programmer;
            end
        end
    end

    assign prdata                  = prdata_q;
    assign pready                  = pready_q;
    assign pslverr                 = pslverr_q;
    assign core_reset_n            = core_reset_n_q;
    assign reset_pin_pullup_en     = pullup_q;
    assign reset_shared_input_port = port_q;
    assign ext_clock_sel           = ext_clk_q;
    assign clock_shared_io_en      = io_en_q;
    assign lowspeed_osc_run        = osc_run_q;
    assign wdt_clk_en              = wdt_en_q;
    assign wdt_clk_forced_ls       = wdt_ls_q;
    assign timer_clk_en            = timer_q;
    assign op_grant                = grant_q;
    assign op_deny                 = deny_q;
    assign op_erase_all            = erase_all_q;
    assign op_write_block          = write_block_q;

    // ==========================================================
    // Checks
    // ==========================================================
    property p_pullup;
        @(posedge pclk) disable iff (!presetn)
        cfg.mode_sel |=> (pullup_q == $past(cfg.pullup_sel));
    endproperty
    a_pullup: assert property (p_pullup) else $error("pull-up does not follow config");

    property p_port_pullup;
        @(posedge pclk) disable iff (!presetn)
        !cfg.mode_sel |=> (pullup_q == $past(pu3_q[obcl_pkg::PU3_RESET_PORT_PULLUP_BIT_BIT]));
    endproperty
    a_port_pullup: assert property (p_port_pullup) else $error("port pull-up wrong");

    property p_reset_pin_mode;
        @(posedge pclk) disable iff (!presetn)
        (cfg.valid && cfg.mode_sel && !reset_pin_in) |-> ##2 !core_reset_n_q;
    endproperty
    a_reset_pin_mode: assert property (p_reset_pin_mode) else $error("pin reset not applied");

    property p_clock_pin;
        @(posedge pclk) disable iff (!presetn)
        cfg.valid |=> (ext_clk_q == (!$past(cfg.raw[obcl_pkg::OB_SRC_HI_BIT])
                       && $past(cfg.raw[obcl_pkg::OB_SRC_LO_BIT]))) && (io_en_q == !ext_clk_q);
    endproperty
    a_clock_pin: assert property (p_clock_pin) else $error("clock pin decode wrong");

    property p_lock_ignores_stop;
        @(posedge pclk) disable iff (!presetn)
        cfg.osc_lock |=> osc_run_q && wdt_en_q && wdt_ls_q;
    endproperty
    a_lock_ignores_stop: assert property (p_lock_ignores_stop) else $error("locked oscillator stopped");

    property p_wdt_gated;
        @(posedge pclk) disable iff (!presetn)
        (!cfg.osc_lock && (halt_mode || stop_mode || !ctrl_q[obcl_pkg::CTRL_WDTLS_BIT])) |=> !wdt_en_q;
    endproperty
    a_wdt_gated: assert property (p_wdt_gated) else $error("watchdog clock not gated");

    property p_stop_halts;
        @(posedge pclk) disable iff (!presetn)
        (!cfg.osc_lock && ctrl_q[obcl_pkg::CTRL_STOP_BIT]) |=> !osc_run_q && !timer_q;
    endproperty
    a_stop_halts: assert property (p_stop_halts) else $error("oscillator stop ignored");

    property p_timer_in_stop;
        @(posedge pclk) disable iff (!presetn)
        (stop_mode && !ctrl_q[obcl_pkg::CTRL_STOP_BIT]) |=> timer_q;
    endproperty
    a_timer_in_stop: assert property (p_timer_in_stop) else $error("timer lost clock in STOP");

    property p_self_protect;
        @(posedge pclk) disable iff (!presetn)
        (op_valid && !op_from_programmer && prot_q[op_block]) |=> deny_q && !grant_q;
    endproperty
    a_self_protect: assert property (p_self_protect) else $error("protected block rewritten");

    property p_chip_erase_self;
        @(posedge pclk) disable iff (!presetn)
        (op_valid && !op_from_programmer && op_cmd == 2'(obcl_pkg::OBCL_OP_CHIP_ERASE)) |=> !erase_all_q;
    endproperty
    a_chip_erase_self: assert property (p_chip_erase_self) else $error("self chip erase granted");

    property p_write_unit;
        @(posedge pclk) disable iff (!presetn)
        op_valid |=> (write_block_q == $past(op_from_programmer));
    endproperty
    a_write_unit: assert property (p_write_unit) else $error("write unit wrong");

    property p_block_range;
        @(posedge pclk) disable iff (!presetn)
        (op_valid && !op_cmd[1] && int'(op_block) >= NUM_BLOCKS) |=> !grant_q;
    endproperty
    a_block_range: assert property (p_block_range) else $error("block outside array granted");

    property p_core_held;
        @(posedge pclk) disable iff (!presetn)
        !cfg.valid |=> !core_reset_n_q;
    endproperty
    a_core_held: assert property (p_core_held) else $error("core released before load");
endmodule : obcl_top

/* File: testbench/obcl_flash_model.sv */
// Flash array model: answers a held fetch with a one-cycle acknowledge.
// Assumes the loader holds its request until acknowledged or the pin drops.
`timescale 1ns/1ps
module obcl_flash_model (
    input  wire logic        pclk,
    input  wire logic [7:0]  cfg_byte,
    input  wire logic [3:0]  lat,
    input  wire logic        flash_rd_req,
    input  wire logic [11:0] flash_rd_addr,
    output logic             flash_rd_ack,
    output logic [7:0]       flash_rd_data
);
    logic       hit;
    logic [3:0] wait_q = 4'h0;
    initial flash_rd_ack = 1'b0;
    initial flash_rd_data = 8'h00;
    assign hit = flash_rd_req && !flash_rd_ack && wait_q >= lat;
    // Data toggles outside the ack cycle so a stale byte never looks valid
    always @(posedge pclk) begin
        flash_rd_ack  <= hit;
        flash_rd_data <= hit ? ((flash_rd_addr === 12'h080) ? cfg_byte : 8'h00) : ~flash_rd_data;
        wait_q        <= (flash_rd_req && !flash_rd_ack) ? wait_q + 4'h1 : 4'h0;
    end
endmodule : obcl_flash_model

/* File: testbench/tb_obcl_top.sv */
// Bench for the boot configuration loader: boots several option bytes and checks pins,
// clocks, registers and rewrite permissions. Assumes the flash model beside it.
`timescale 1ns/1ps
module tb_obcl_top;
    // ==========================================================
    // Signals
    // ==========================================================
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, flash_rd_req, flash_rd_ack, reset_pin_in;
    logic halt_mode, stop_mode, op_valid, op_from_programmer, core_reset_n, reset_pin_pullup_en;
    logic reset_shared_input_port, ext_clock_sel, clock_shared_io_en, lowspeed_osc_run, wdt_clk_en;
    logic wdt_clk_forced_ls, timer_clk_en, op_grant, op_deny, op_erase_all, op_write_block, er;
    logic [7:0]  paddr, flash_rd_data, cfg_byte;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] flash_rd_addr;
    logic [3:0]  op_block, lat;
    logic [1:0]  op_cmd;
    int          n_mismatch = 0, checks = 0, cyc = 0;
    obcl_top #(.FLASH_KB(1)) obcl_top_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
        .pready, .pslverr, .flash_rd_req, .flash_rd_addr, .flash_rd_ack, .flash_rd_data, .reset_pin_in,
        .halt_mode, .stop_mode, .op_valid, .op_cmd, .op_from_programmer, .op_block, .core_reset_n,
        .reset_pin_pullup_en, .reset_shared_input_port, .ext_clock_sel, .clock_shared_io_en,
        .lowspeed_osc_run, .wdt_clk_en, .wdt_clk_forced_ls, .timer_clk_en, .op_grant, .op_deny,
        .op_erase_all, .op_write_block);
    obcl_flash_model obcl_flash_model_i (.pclk, .cfg_byte, .lat, .flash_rd_req, .flash_rd_addr,
        .flash_rd_ack, .flash_rd_data);
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end
    // ==========================================================
    // Tasks
    // ==========================================================
    task automatic close_out;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic wait_core;
        int n = 0;
        while (core_reset_n !== 1'b1 && n < 60) begin
            @(posedge pclk);
            n++;
        end
        repeat (2) @(posedge pclk);
        chk(core_reset_n, 1, "core release");
    endtask : wait_core
    task automatic op(input obcl_pkg::obcl_op_t c, input logic p, input logic [3:0] b, input logic [2:0] e);
        op_valid <= 1'b1; op_cmd <= c; op_from_programmer <= p; op_block <= b;
        @(posedge pclk);
        op_valid <= 1'b0;
        @(negedge pclk);
        chk({op_grant, op_deny, op_erase_all, op_write_block}, {e, p}, "flash op");
        @(posedge pclk);
    endtask : op
    // Hang guard, far above the few hundred cycles the sequence needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 6000) begin
            n_mismatch++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end
    // ==========================================================
    // Sequence
    // ==========================================================
    initial begin
        static logic [7:0] obs [5] = '{8'hfc, 8'he3, 8'hf7, 8'hf1, 8'hea};
        logic [7:0] ob;
        {presetn, psel, penable, pwrite, halt_mode, stop_mode, op_valid, op_from_programmer} <= 8'h00;
        {paddr, pwdata, op_cmd, op_block} <= '0;
        {reset_pin_in, cfg_byte, lat} <= {1'b0, 8'hfc, 4'h1};
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        chk(core_reset_n, 0, "pin low hold");
        reset_pin_in <= 1'b1;
        wait_core();
        for (int i = 0; i < 5; i++) begin
            ob = obs[i];
            presetn <= 1'b0; cfg_byte <= ob; lat <= 4'(i * 3);
            repeat (12) @(posedge pclk);
            // Pin stays high through power-up, as a connected programmer would hold it
            presetn <= 1'b1;
            wait_core();
            chk(reset_pin_pullup_en, ob[4] & ob[3], "pullup");
            chk(ext_clock_sel, ob[2:1] == 2'b01, "ext clock");
            chk(clock_shared_io_en, ob[2:1] != 2'b01, "clock pin io");
            chk(wdt_clk_forced_ls, ob[0], "wdt forced");
            apb(1'b0, obcl_pkg::REG_OPTB, 32'h0);
            chk(rd, {24'h0, ob}, "option byte");
            apb(1'b1, obcl_pkg::REG_PU3, 32'h10);
            repeat (3) @(posedge pclk);
            chk(reset_pin_pullup_en, ob[4] | !ob[3], "port pullup");
            apb(1'b1, obcl_pkg::REG_CTRL, 32'h3);
            stop_mode <= 1'b1;
            repeat (3) @(posedge pclk);
            chk(lowspeed_osc_run, ob[0], "osc stop");
            chk(timer_clk_en, ob[0], "timer in stop");
            chk(wdt_clk_en, ob[0], "wdt in stop");
            stop_mode <= 1'b0;
            apb(1'b1, obcl_pkg::REG_CTRL, 32'h0);
            repeat (3) @(posedge pclk);
            chk(wdt_clk_en, ob[0], "wdt other source");
            halt_mode <= 1'b1;
            apb(1'b1, obcl_pkg::REG_CTRL, 32'h2);
            repeat (3) @(posedge pclk);
            chk(wdt_clk_en, ob[0], "wdt in halt");
            halt_mode <= 1'b0;
            repeat (3) @(posedge pclk);
            chk(wdt_clk_en, 1, "wdt runs");
            reset_pin_in <= 1'b0;
            repeat (4) @(posedge pclk);
            chk(core_reset_n, !ob[3], "pin reset");
            reset_pin_in <= 1'b1;
            repeat (3) @(posedge pclk);
            chk(reset_shared_input_port, !ob[3], "pin as port");
            wait_core();
        end
        apb(1'b0, obcl_pkg::REG_STAT, 32'h0);
        chk(rd[15:8], 4, "block count");
        apb(1'b0, 8'h40, 32'h0);
        chk({er, rd[30:0]}, 32'h80000000, "unmapped");
        op(obcl_pkg::OBCL_OP_WRITE, 1'b0, 4'h1, 3'b100);
        op(obcl_pkg::OBCL_OP_WRITE, 1'b1, 4'h1, 3'b100);
        op(obcl_pkg::OBCL_OP_CHIP_ERASE, 1'b1, 4'h0, 3'b101);
        op(obcl_pkg::OBCL_OP_CHIP_ERASE, 1'b0, 4'h0, 3'b010);
        op(obcl_pkg::OBCL_OP_BLK_ERASE, 1'b0, 4'h3, 3'b100);
        op(obcl_pkg::OBCL_OP_BLK_ERASE, 1'b0, 4'h4, 3'b010);
        apb(1'b1, obcl_pkg::REG_PROT, 32'h4);
        op(obcl_pkg::OBCL_OP_WRITE, 1'b0, 4'h2, 3'b010);
        apb(1'b1, obcl_pkg::REG_SEC, 32'h4);
        op(obcl_pkg::OBCL_OP_WRITE, 1'b1, 4'h1, 3'b010);
        close_out();
    end
endmodule : tb_obcl_top
